// ===== pio_pkg.sv
// constants of the parallel i/o ports: addresses, reset values, masks, modes
// assumes one 100 MHz clock and an internal cpu bus with byte data
package pio_pkg;
  localparam int NPORT = 9;
  localparam int PW    = 8;
  // index 0 is port 1, index 8 is port 9
  localparam logic [8:0][7:0] PORT_MASK = {8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF};
  localparam logic [8:0]      HAS_DDR   = 9'h17F;
  localparam logic [8:0][7:0] DDR_RST   = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
  localparam logic [7:0]      DR_RST    = 8'h00;
  localparam logic [7:0]      P1_DR_WMASK = 8'hFC;
  localparam logic [7:0]      DDR_READ  = 8'hFF;
  // port n direction at DDR_BASE + 4*(n-1), data two bytes above
  localparam logic [15:0] DDR_BASE  = 16'hFF80;
  localparam logic [15:0] PORT_STEP = 16'h0004;
  localparam logic [15:0] DR_OFS    = 16'h0002;
  localparam logic [15:0] PORT_ONE_FUNCTION_CONTROL_ADDR = 16'hFFFC;
  localparam logic [7:0]  PORT_ONE_FUNCTION_CONTROL_RST  = 8'h87;
  localparam logic [7:0]  PORT_ONE_FUNCTION_CONTROL_FIX  = 8'h87;
  localparam int PORT_ONE_FUNCTION_CONTROL_IRQB  = 6;
  localparam int PORT_ONE_FUNCTION_CONTROL_IRQA  = 5;
  localparam int PORT_ONE_FUNCTION_CONTROL_NMIEG = 4;
  localparam int PORT_ONE_FUNCTION_CONTROL_BRLE  = 3;
  localparam logic [2:0] MODE_SINGLE = 3'h7;
  localparam logic [2:0] MODE_EXP1   = 3'h1;
  localparam logic [2:0] MODE_EXP2   = 3'h2;
  localparam logic [2:0] MODE_EXP3   = 3'h3;
  localparam logic [2:0] MODE_EXP4   = 3'h4;
  localparam int P_BUS_STB = 1;
  localparam int P_DATA    = 2;
  localparam int P_ADDR_LO = 3;
  localparam int P_ADDR_HI = 4;
  localparam int P_PAGE    = 5;
  localparam int P_TIMER   = 6;
  localparam int P_ANALOG  = 7;
  localparam int P_SERIAL  = 8;
endpackage : pio_pkg

// ===== pio_ports.sv
// the nine parallel i/o ports, all but port 8 with direction and data latches, and pin sharing
// assumes pins are asynchronous; peripherals on mclk supply alternate signals
`timescale 1ns/1ps
module pio_ports (
  input  wire logic            mclk,                    // system clock
  input  wire logic            rst,                     // async reset, high
  input  wire logic [2:0]      mode,                    // operating mode pins
  input  wire logic [15:0]     cpu_addr,                // internal bus address
  input  wire logic            cpu_we,                  // write strobe
  input  wire logic            cpu_re,                  // read strobe
  input  wire logic [7:0]      cpu_wdata,               // write data
  output logic      [7:0]      cpu_rdata,               // read data, next cycle
  input  wire logic [8:0][7:0] pin_i,                   // pin levels
  output logic      [8:0][7:0] pin_o,                   // pin drive values
  output logic      [8:0][7:0] pin_oe,                  // pin drive enables
  output logic      [8:0][7:0] pin_level,               // synchronised pin levels
  input  wire logic [8:0][7:0] alt_o,                   // peripheral pin outputs
  input  wire logic [8:0][7:0] alt_en,                  // peripheral claims pin
  input  wire logic            small_timer_compare_out, // timer output on port 1 bit 7
  input  wire logic            tmo_en,                  // timer output enable
  input  wire logic            sys_clk_out,             // system clock for port 1 bit 0
  input  wire logic            e_clk_out,               // e clock for port 1 bit 1
  input  wire logic            bus_release_ack,         // bus grant out on port 1 bit 2
  output logic                 bus_release_request,     // port 1 bit 3 in, gated
  output logic                 ext_interrupt_req_a,     // port 1 bit 5 in, gated
  output logic                 ext_interrupt_req_b,     // port 1 bit 6 in, gated
  output logic                 nmi_rising,              // nmi edge select
  input  wire logic [4:0]      bus_strobes,             // write, read, data, r/w, address strobe
  input  wire logic [19:0]     ext_addr,                // external address
  input  wire logic [7:0]      ext_data_out,            // external write data
  input  wire logic            ext_data_oe,             // drive data bus
  output logic      [7:0]      ext_data_in,             // external read data
  output logic                 expanded                 // expanded mode active
);
  logic [8:0][7:0] ddr_reg, ddr_next;
  logic [8:0][7:0] dr_reg, dr_next;
  logic [7:0]      port_one_function_control_reg, port_one_function_control_next;
  logic [8:0][7:0] sync1_reg, sync2_reg;
  logic [7:0]      rdata_reg, rdata_next;
  logic [7:0]      rd_val;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction : hit

  assign expanded = (mode == pio_pkg::MODE_EXP1) || (mode == pio_pkg::MODE_EXP2) ||
                    (mode == pio_pkg::MODE_EXP3) || (mode == pio_pkg::MODE_EXP4);

  // two-flop synchronisers on every pin
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
    end
  end
  assign pin_level   = sync2_reg;
  assign ext_data_in = sync2_reg[pio_pkg::P_DATA];

  // register writes
  always_comb begin
    ddr_next  = ddr_reg;
    dr_next   = dr_reg;
    port_one_function_control_next = port_one_function_control_reg;
    if (cpu_we) begin
      for (int i = 0; i < pio_pkg::NPORT; i++) begin
        if (pio_pkg::HAS_DDR[i] &&
            hit(cpu_addr, 16'(pio_pkg::DDR_BASE + pio_pkg::PORT_STEP * 16'(i)))) begin
          ddr_next[i] = cpu_wdata & pio_pkg::PORT_MASK[i];
        end
        if (pio_pkg::HAS_DDR[i] &&
            hit(cpu_addr, 16'(pio_pkg::DDR_BASE + pio_pkg::PORT_STEP * 16'(i) + pio_pkg::DR_OFS))) begin
          dr_next[i] = cpu_wdata & pio_pkg::PORT_MASK[i] &
                       ((i == 0) ? pio_pkg::P1_DR_WMASK : 8'hFF);
        end
      end
      if (hit(cpu_addr, pio_pkg::PORT_ONE_FUNCTION_CONTROL_ADDR)) begin
        port_one_function_control_next = (cpu_wdata & ~pio_pkg::PORT_ONE_FUNCTION_CONTROL_FIX) | pio_pkg::PORT_ONE_FUNCTION_CONTROL_FIX;
      end
    end
  end

  // read mux: input pins from the synchroniser, output pins from the latch, port 1 output bits 0 and 1 from the clocks
  always_comb begin
    rd_val = 8'h00;
    for (int i = 0; i < pio_pkg::NPORT; i++) begin
      if (pio_pkg::HAS_DDR[i] && hit(cpu_addr, 16'(pio_pkg::DDR_BASE + pio_pkg::PORT_STEP * 16'(i)))) begin
        rd_val = pio_pkg::DDR_READ;
      end
      if (hit(cpu_addr, 16'(pio_pkg::DDR_BASE + pio_pkg::PORT_STEP * 16'(i) + pio_pkg::DR_OFS))) begin
        rd_val = ((dr_reg[i] & ddr_reg[i]) | (sync2_reg[i] & ~ddr_reg[i])) & pio_pkg::PORT_MASK[i];
        if (i == 0) begin
          if (ddr_reg[0][0]) begin
            rd_val[0] = sys_clk_out;
          end
          if (ddr_reg[0][1]) begin
            rd_val[1] = e_clk_out;
          end
        end
      end
    end
    if (hit(cpu_addr, pio_pkg::PORT_ONE_FUNCTION_CONTROL_ADDR)) begin
      rd_val = port_one_function_control_reg;
    end
    rdata_next = cpu_re ? rd_val : rdata_reg;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ddr_reg   <= pio_pkg::DDR_RST;
      dr_reg    <= '0;
      port_one_function_control_reg  <= pio_pkg::PORT_ONE_FUNCTION_CONTROL_RST;
      rdata_reg <= 8'h00;
    end else begin
      ddr_reg   <= ddr_next;
      dr_reg    <= dr_next;
      port_one_function_control_reg  <= port_one_function_control_next;
      rdata_reg <= rdata_next;
    end
  end
  assign cpu_rdata = rdata_reg;

  // pin drive: general i/o, then alternate functions override
  always_comb begin
    for (int i = 0; i < pio_pkg::NPORT; i++) begin
      pin_o[i]  = dr_reg[i] & pio_pkg::PORT_MASK[i];
      pin_oe[i] = ddr_reg[i] & pio_pkg::PORT_MASK[i];
    end
    pin_oe[pio_pkg::P_ANALOG] = 8'h00;
    // port 1
    pin_o[0][0] = sys_clk_out;
    pin_o[0][1] = e_clk_out;
    if (tmo_en) begin
      pin_o[0][7]  = small_timer_compare_out;
      pin_oe[0][7] = 1'b1;
    end
    if (port_one_function_control_reg[pio_pkg::PORT_ONE_FUNCTION_CONTROL_IRQB]) begin
      pin_oe[0][6] = 1'b0;
    end
    if (port_one_function_control_reg[pio_pkg::PORT_ONE_FUNCTION_CONTROL_IRQA]) begin
      pin_oe[0][5] = 1'b0;
    end
    if (expanded && port_one_function_control_reg[pio_pkg::PORT_ONE_FUNCTION_CONTROL_BRLE]) begin
      pin_oe[0][3] = 1'b0;
      pin_o[0][2]  = bus_release_ack;
      pin_oe[0][2] = 1'b1;
    end
    // ports 7 and 9 lend pins to timers and the serial interface
    for (int i = pio_pkg::P_TIMER; i < pio_pkg::NPORT; i += 2) begin
      for (int b = 0; b < pio_pkg::PW; b++) begin
        if (alt_en[i][b]) begin
          pin_o[i][b]  = alt_o[i][b];
          pin_oe[i][b] = 1'b1;
        end
      end
    end
    // external bus in expanded modes
    if (expanded) begin
      pin_o[pio_pkg::P_BUS_STB]  = {3'h0, bus_strobes};
      pin_oe[pio_pkg::P_BUS_STB] = pio_pkg::PORT_MASK[pio_pkg::P_BUS_STB];
      pin_o[pio_pkg::P_DATA]     = ext_data_out;
      pin_oe[pio_pkg::P_DATA]    = {8{ext_data_oe}};
      pin_o[pio_pkg::P_ADDR_LO]  = ext_addr[7:0];
      pin_oe[pio_pkg::P_ADDR_LO] = 8'hFF;
      if (mode == pio_pkg::MODE_EXP1 || mode == pio_pkg::MODE_EXP3) begin
        pin_o[pio_pkg::P_ADDR_HI]  = ext_addr[15:8];
        pin_oe[pio_pkg::P_ADDR_HI] = 8'hFF;
      end else begin
        pin_o[pio_pkg::P_ADDR_HI] = ext_addr[15:8];
      end
      if (mode == pio_pkg::MODE_EXP3) begin
        pin_o[pio_pkg::P_PAGE]  = {4'h0, ext_addr[19:16]};
        pin_oe[pio_pkg::P_PAGE] = pio_pkg::PORT_MASK[pio_pkg::P_PAGE];
      end else if (mode == pio_pkg::MODE_EXP4) begin
        pin_o[pio_pkg::P_PAGE] = {4'h0, ext_addr[19:16]};
      end
    end
  end

  assign ext_interrupt_req_b = port_one_function_control_reg[pio_pkg::PORT_ONE_FUNCTION_CONTROL_IRQB] & sync2_reg[0][6];
  assign ext_interrupt_req_a = port_one_function_control_reg[pio_pkg::PORT_ONE_FUNCTION_CONTROL_IRQA] & sync2_reg[0][5];
  assign bus_release_request = expanded & port_one_function_control_reg[pio_pkg::PORT_ONE_FUNCTION_CONTROL_BRLE] & sync2_reg[0][3];
  assign nmi_rising          = port_one_function_control_reg[pio_pkg::PORT_ONE_FUNCTION_CONTROL_NMIEG];

  property p_port8_input;
    @(posedge mclk) disable iff (rst) pin_oe[pio_pkg::P_ANALOG] == 8'h00;
  endproperty
  a_port8_input: assert property (p_port8_input) else $error("port 8 driven");

  property p_gpio_dir;
    @(posedge mclk) disable iff (rst)
      mode == pio_pkg::MODE_SINGLE |-> pin_oe[3] == ddr_reg[3] && pin_o[3] == dr_reg[3];
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("port 4 direction wrong");

  property p_dr_write;
    @(posedge mclk) disable iff (rst)
      cpu_we && cpu_addr == 16'hFF8E |=> dr_reg[3] == $past(cpu_wdata);
  endproperty
  a_dr_write: assert property (p_dr_write) else $error("latch not loaded");

  property p_read_mix;
    @(posedge mclk) disable iff (rst)
      cpu_re && cpu_addr == 16'hFF8E |=>
        cpu_rdata == (($past(dr_reg[3]) & $past(ddr_reg[3])) | ($past(sync2_reg[3]) & ~$past(ddr_reg[3])));
  endproperty
  a_read_mix: assert property (p_read_mix) else $error("data read wrong");

  property p_addr_lo;
    @(posedge mclk) disable iff (rst)
      expanded |-> pin_oe[3] == 8'hFF && pin_o[3] == ext_addr[7:0];
  endproperty
  a_addr_lo: assert property (p_addr_lo) else $error("low address missing");

  property p_strobes;
    @(posedge mclk) disable iff (rst)
      expanded |-> pin_oe[1] == 8'h1F && pin_o[1][4:0] == bus_strobes;
  endproperty
  a_strobes: assert property (p_strobes) else $error("strobes missing");

  property p_irq_pin;
    @(posedge mclk) disable iff (rst)
      port_one_function_control_reg[pio_pkg::PORT_ONE_FUNCTION_CONTROL_IRQB] |-> !pin_oe[0][6] && ext_interrupt_req_b == sync2_reg[0][6];
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin wrong");

  property p_port_one_function_control_fixed;
    @(posedge mclk) disable iff (rst) (port_one_function_control_reg & pio_pkg::PORT_ONE_FUNCTION_CONTROL_FIX) == pio_pkg::PORT_ONE_FUNCTION_CONTROL_FIX;
  endproperty
  a_port_one_function_control_fixed: assert property (p_port_one_function_control_fixed) else $error("fixed control bits lost");

  property p_addr_hi_ddr;
    @(posedge mclk) disable iff (rst)
      mode == pio_pkg::MODE_EXP2 |-> pin_oe[4] == ddr_reg[4] && pin_o[4] == ext_addr[15:8];
  endproperty
  a_addr_hi_ddr: assert property (p_addr_hi_ddr) else $error("high address by direction wrong");

  property p_mode7_data;
    @(posedge mclk) disable iff (rst)
      mode == pio_pkg::MODE_SINGLE |-> pin_oe[2] == ddr_reg[2] && pin_o[1] == dr_reg[1];
  endproperty
  a_mode7_data: assert property (p_mode7_data) else $error("single chip port not plain");
endmodule : pio_ports

// ===== pio_pin_model.sv
// pin-side model: outside circuitry that resolves each port pin
// assumes the bench gives the level that outside parts drive on free pins
`timescale 1ns/1ps
module pio_pin_model (
  input  wire logic [8:0][7:0] pin_o,   // device drive value
  input  wire logic [8:0][7:0] pin_oe,  // device drive enable
  input  wire logic [8:0][7:0] ext_lvl, // outside drive level
  output logic      [8:0][7:0] pin_i    // resolved pin level
);
  // a driven pin shows the device value, a free pin the outside level
  assign pin_i = (pin_o & pin_oe) | (ext_lvl & ~pin_oe);
endmodule : pio_pin_model

// ===== tb_top.sv
// self-checking bench for the parallel i/o ports with a reference model
// assumes pio_pkg, pio_ports and pio_pin_model are compiled first
`timescale 1ns/1ps
module tb_top;
  logic mclk = 0, rst = 1, cpu_we = 0, cpu_re = 0, tmo_en = 0, tmo_v = 0, ext_data_oe = 0;
  logic bra, irqa, irqb, nmi_r, expd, sclk = 0, eclk = 0, back = 0;
  logic [2:0]      mode = 3'h7;
  logic [15:0]     cpu_addr = 16'h0000;
  logic [7:0]      cpu_wdata = 8'h00, ext_data_out = 8'h00, cpu_rdata, ext_data_in, r, seed = 8'h5D;
  logic [8:0][7:0] pin_i, pin_o, pin_oe, pin_level, ext_lvl = '0, alt_o = '0, alt_en = '0;
  logic [4:0]      strobes = 5'h15;
  logic [19:0]     ext_addr = 20'hA_5C3E;
  int              err_count = 0, cmp_count = 0, ddr_m[9], dr_m[9];
  always #5 mclk = ~mclk;
  pio_ports DUT (.mclk(mclk), .rst(rst), .mode(mode), .cpu_addr(cpu_addr), .cpu_we(cpu_we), .cpu_re(cpu_re),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_level(pin_level), .alt_o(alt_o), .alt_en(alt_en), .small_timer_compare_out(tmo_v), .tmo_en(tmo_en),
    .sys_clk_out(sclk), .e_clk_out(eclk), .bus_release_ack(back), .bus_release_request(bra),
    .ext_interrupt_req_a(irqa), .ext_interrupt_req_b(irqb), .nmi_rising(nmi_r), .bus_strobes(strobes),
    .ext_addr(ext_addr), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in),
    .expanded(expd));
  pio_pin_model pins (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_i(pin_i));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic conclude();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_we    <= 1'b1;
    @(posedge mclk);
    cpu_we    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge mclk);
    cpu_addr <= a;
    cpu_re   <= 1'b1;
    @(posedge mclk);
    cpu_re   <= 1'b0;
    #1 r = cpu_rdata;
  endtask : rd
  task automatic reset_mode(input logic [2:0] m);
    @(posedge mclk);
    rst  <= 1'b1;
    mode <= m;
    repeat (2) @(posedge mclk);
    rst  <= 1'b0;
    foreach (ddr_m[i]) begin
      ddr_m[i] = 0;
      dr_m[i]  = 0;
    end
    ddr_m[0] = 3;
    #1;
  endtask : reset_mode
  function automatic logic [15:0] pa(input int i);
    return pio_pkg::DDR_BASE + pio_pkg::PORT_STEP * i[15:0];
  endfunction : pa
  initial begin
    #100_000;
    err_count++;
    conclude();
  end
  initial begin
    logic [7:0] d, m;
    reset_mode(3'h7);
    chk(pin_oe[0], 8'h03);
    chk({7'h00, expd}, 8'h00);
    rd(pio_pkg::PORT_ONE_FUNCTION_CONTROL_ADDR); chk(r, 8'h87);
    rd(pa(0)); chk(r, 8'hFF);
    wr(16'hFF9C, 8'hFF);
    rd(16'hFF9C); chk(r, 8'h00);
    for (int rep = 0; rep < 3; rep++) begin
      for (int i = 0; i < 9; i++) begin
        m = pio_pkg::PORT_MASK[i];
        seed = lfsr(seed);
        d = (i == 0) ? (seed & 8'hFC) : seed;
        if (i != 7) begin
          wr(pa(i), d);
          ddr_m[i] = d;
        end
        seed = lfsr(seed);
        wr(pa(i) + pio_pkg::DR_OFS, seed);
        dr_m[i] = (i == 0) ? (seed & 8'hFC) : seed;
        seed = lfsr(seed);
        ext_lvl[i] <= seed;
        repeat (4) @(posedge mclk);
        rd(pa(i) + pio_pkg::DR_OFS);
        chk(r & m, ((dr_m[i] & ddr_m[i]) | (seed & ~ddr_m[i])) & m);
        chk(pin_oe[i], ddr_m[i] & m);
        chk(pin_o[i] & pin_oe[i], dr_m[i] & ddr_m[i] & m);
        chk(pin_level[i], (dr_m[i] & ddr_m[i] & m) | (seed & ~(ddr_m[i] & m)));
      end
    end
    @(posedge mclk);
    alt_en[6] <= 8'h81;
    alt_o[6]  <= 8'h80;
    alt_en[8] <= 8'h0C;
    alt_o[8]  <= seed & 8'h0C;
    @(posedge mclk);
    #1 chk(pin_oe[6], ddr_m[6] | 8'h81);
    chk(pin_o[6] & 8'h81, 8'h80);
    chk(pin_oe[8], ddr_m[8] | 8'h0C);
    chk(pin_o[8] & 8'h0C, seed & 8'h0C);
    wr(pio_pkg::PORT_ONE_FUNCTION_CONTROL_ADDR, 8'h70);
    rd(pio_pkg::PORT_ONE_FUNCTION_CONTROL_ADDR); chk(r, 8'hF7);
    @(posedge mclk);
    ext_lvl[0] <= 8'h60;
    tmo_en     <= 1'b1;
    tmo_v      <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk({4'h0, irqa, irqb, pin_oe[0][6:5]}, 8'h0C);
    chk({6'h00, nmi_r, pin_o[0][7] & pin_oe[0][7]}, 8'h03);
    wr(pa(0), 8'h03);
    sclk <= 1'b1;
    eclk <= 1'b1;
    rd(pa(0) + pio_pkg::DR_OFS); chk(r & 8'h03, 8'h03);
    chk(pin_o[0] & pin_oe[0], 8'h83);
    reset_mode(3'h1);
    @(posedge mclk);
    ext_data_oe  <= 1'b1;
    ext_data_out <= 8'h3C;
    @(posedge mclk);
    #1 chk({7'h00, expd}, 8'h01);
    chk(pin_o[1] & 8'h1F, {3'h0, strobes});
    chk(pin_oe[1], 8'h1F);
    chk(pin_o[2] & pin_oe[2], 8'h3C);
    chk(pin_o[3] & pin_oe[3], ext_addr[7:0]);
    chk(pin_o[4] & pin_oe[4], ext_addr[15:8]);
    chk(pin_oe[5], 8'h00);
    @(posedge mclk);
    ext_data_oe <= 1'b0;
    ext_lvl[2]  <= 8'h96;
    repeat (4) @(posedge mclk);
    #1 chk(ext_data_in, 8'h96);
    wr(pio_pkg::PORT_ONE_FUNCTION_CONTROL_ADDR, 8'h08);
    ext_lvl[0] <= 8'h08;
    back       <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk({5'h00, bra, pin_o[0][2] & pin_oe[0][2], pin_oe[0][3]}, 8'h06);
    reset_mode(3'h3);
    chk(pin_oe[5], 8'h0F);
    chk(pin_o[5] & 8'h0F, {4'h0, ext_addr[19:16]});
    reset_mode(3'h2);
    wr(pa(4), 8'h0F);
    #1 chk(pin_oe[4], 8'h0F);
    chk(pin_o[4] & pin_oe[4], ext_addr[15:8] & 8'h0F);
    conclude();
  end
endmodule : tb_top
